//--- include/ptl_pkg.sv
// types shared by the telemetry and limits command handler
`default_nettype none
package ptl_pkg;
  // link byte engine states, gray along rx-ack-tx-rack
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_RACK = 3'h6
  } ptl_state_t;
endpackage
`default_nettype wire

//--- include/ptl_regs.svh
// command codes, reset values, field positions and timing figures
`ifndef PTL_REGS_SVH
`define PTL_REGS_SVH
// command codes
`define PTL_CMD_OPER   8'h01
`define PTL_CMD_OTF    8'h4F
`define PTL_CMD_OTW    8'h51
`define PTL_CMD_OVF    8'h55
`define PTL_CMD_OVW    8'h57
`define PTL_CMD_OCF    8'h5B
`define PTL_CMD_OCW    8'h5D
`define PTL_CMD_TON    8'h60
`define PTL_CMD_HV     8'h88
`define PTL_CMD_HI     8'h89
`define PTL_CMD_LV     8'h8B
`define PTL_CMD_LI     8'h8C
`define PTL_CMD_TMP    8'h8D
`define PTL_CMD_RES    8'hD4
`define PTL_CMD_UVD    8'hD7
// reset values: limits at full protection value
`define PTL_RST_OVF    16'h10FE
`define PTL_RST_OCF    16'h157C
`define PTL_RST_OTF    16'h007D
`define PTL_RST_TON    16'h0000
`define PTL_RST_UVD    16'h0000
`define PTL_RST_PINS   6'h30
`define PTL_DIS_LV     16'hF448
`define PTL_DIS_TMP    16'hFEEF
`define PTL_BAD_CMD    16'hFFFF
`define PTL_UV_NOMINAL 16'h08CA
`define PTL_UV_DEFAULT 16'h0A28
`define PTL_TON_MAX    16'h0064
`define PTL_UV_DELAY   16'h0014
`define PTL_OVLO_PCT   32'h3
`define PTL_PCT_FULL   32'h64
// field positions
`define PTL_OPER_ON_BIT 7
`define PTL_UVD_BIT     0
// address strap
`define PTL_ADDR_BASE  7'h10
`define PTL_BAND_QMV   14'h0339
// timing
`define PTL_CLK_MHZ    125
`define PTL_FAST_US    100
`define PTL_SLOW_MS    100
`define PTL_READY_US   1500
`define PTL_COMMIT_MS  3
`endif

//--- rtl/ptl_core.sv
// management command handler: telemetry reads and protection limit writes
`include "ptl_regs.svh"
`default_nettype none
module ptl_core import ptl_pkg::*; #(
  parameter int FAST_CYC   = `PTL_FAST_US * `PTL_CLK_MHZ,
  parameter int SLOW_CYC   = `PTL_SLOW_MS * 1000 * `PTL_CLK_MHZ,
  parameter int READY_CYC  = `PTL_READY_US * `PTL_CLK_MHZ,
  parameter int COMMIT_CYC = `PTL_COMMIT_MS * 1000 * `PTL_CLK_MHZ
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        bias_supply_pin,
  input  wire logic        hi_below_uv,
  input  wire logic        fwd_dir,
  input  wire logic        hi_present,
  input  wire logic [11:0] strap_mv,
  input  wire logic [15:0] hi_v_raw,
  input  wire logic [15:0] hi_i_raw,
  input  wire logic [15:0] lo_v_raw,
  input  wire logic [15:0] lo_i_raw,
  input  wire logic [15:0] lo_r_raw,
  input  wire logic [15:0] temp_raw,
  output logic             module_on,
  output logic             bus_active,
  output logic [6:0]       bus_addr,
  output logic [15:0]      ovf,
  output logic [15:0]      ovw,
  output logic [15:0]      ocf,
  output logic [15:0]      ocw,
  output logic [15:0]      otf,
  output logic [15:0]      otw,
  output logic [15:0]      ton,
  output logic [15:0]      uvd,
  output logic [15:0]      hi_side_overvoltage_lockout_point,
  output logic [15:0]      hi_side_undervoltage_threshold,
  output logic [15:0]      start_delay_ms,
  output logic             commit_busy,
  output logic             nvm_commit
);
  // ---------------------------------------------------------------
  // pin synchronisers and link edges
  // ---------------------------------------------------------------
  logic [5:0]  pin_q1;
  logic [5:0]  pin_q2;
  logic        scl_d;
  logic        sda_d;
  // first stage is read only by the second
  // link lines reset to their idle high level so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_q1 <= `PTL_RST_PINS;
      pin_q2 <= `PTL_RST_PINS;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      pin_q1 <= {scl_i, sda_i, bias_supply_pin, hi_below_uv, fwd_dir, hi_present};
      pin_q2 <= pin_q1;
      scl_d  <= pin_q2[5];
      sda_d  <= pin_q2[4];
    end
  end
  wire scl_s    = pin_q2[5];
  wire sda_s    = pin_q2[4];
  wire bias_s   = pin_q2[3];
  wire below_s  = pin_q2[2];
  wire fwd_s    = pin_q2[1];
  wire hpres_s  = pin_q2[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ---------------------------------------------------------------
  // start-up: link ready timer and address strap
  // ---------------------------------------------------------------
  logic [23:0] rdy_cnt;
  logic        addr_ok;
  wire  [13:0] strap_q   = {strap_mv, 2'b00};
  wire  [13:0] band_raw  = strap_q / `PTL_BAND_QMV;
  wire  [3:0]  band      = (band_raw > 14'h000F) ? 4'hF : band_raw[3:0];
  wire  [6:0]  strap_addr = `PTL_ADDR_BASE + {3'h0, band};
  wire         rdy_done  = rdy_cnt == 24'(READY_CYC - 1);
  // address caught once; top band clamps so 3.3 V stays in range
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdy_cnt    <= 24'h000000;
      bus_active <= 1'b0;
      addr_ok    <= 1'b0;
      bus_addr   <= 7'h00;
    end else begin
      if (!bias_s) rdy_cnt <= 24'h000000;  // a bias dropout restarts the wait
      else if (!bus_active) rdy_cnt <= rdy_cnt + 24'h000001;
      if (bias_s && rdy_done) bus_active <= 1'b1;
      if (bus_active && !addr_ok) begin
        addr_ok  <= 1'b1;
        bus_addr <= strap_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // telemetry snapshots
  // ---------------------------------------------------------------
  logic [23:0] fast_cnt;
  logic [23:0] slow_cnt;
  logic [15:0] snap_hv, snap_hi, snap_lv, snap_li, snap_r, snap_t;
  wire tick_fast = fast_cnt == 24'(FAST_CYC - 1);
  wire tick_slow = slow_cnt == 24'(SLOW_CYC - 1);
  // no bias and no input power: contents cannot be held
  wire lose = ~bias_s & ~hpres_s;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fast_cnt <= 24'h000000;
      slow_cnt <= 24'h000000;
    end else begin
      fast_cnt <= tick_fast ? 24'h000000 : fast_cnt + 24'h000001;
      slow_cnt <= tick_slow ? 24'h000000 : slow_cnt + 24'h000001;
    end
  end
  // refresh runs regardless of bias
  always_ff @(posedge core_clk) begin
    if (srst || lose) begin
      {snap_hv, snap_hi, snap_lv, snap_li} <= 64'h0;
      {snap_r, snap_t} <= 32'h0;
    end else begin
      if (tick_fast) begin
        snap_hv <= hi_v_raw;
        snap_hi <= hi_i_raw;
        snap_lv <= lo_v_raw;
        snap_li <= lo_i_raw;
      end
      if (tick_slow) begin
        snap_r <= lo_r_raw;
        snap_t <= temp_raw;
      end
    end
  end

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  logic [7:0]  cmd;
  wire  [15:0] rd_lv = module_on ? snap_lv : `PTL_DIS_LV;
  wire  [15:0] rd_t  = module_on ? snap_t : `PTL_DIS_TMP;
  wire  [15:0] rd_hi = fwd_s ? snap_hi : 16'h0000;
  wire  [15:0] rd_li = fwd_s ? snap_li : 16'h0000;
  wire  [15:0] rd_value =
      (cmd == `PTL_CMD_HV)   ? snap_hv :
      (cmd == `PTL_CMD_HI)   ? rd_hi :
      (cmd == `PTL_CMD_LV)   ? rd_lv :
      (cmd == `PTL_CMD_LI)   ? rd_li :
      (cmd == `PTL_CMD_TMP)  ? rd_t :
      (cmd == `PTL_CMD_RES)  ? snap_r :
      (cmd == `PTL_CMD_OPER) ? {8'h00, module_on, 7'h00} :
      (cmd == `PTL_CMD_OVF)  ? ovf :
      (cmd == `PTL_CMD_OVW)  ? ovw :
      (cmd == `PTL_CMD_OCF)  ? ocf :
      (cmd == `PTL_CMD_OCW)  ? ocw :
      (cmd == `PTL_CMD_OTF)  ? otf :
      (cmd == `PTL_CMD_OTW)  ? otw :
      (cmd == `PTL_CMD_TON)  ? ton :
      (cmd == `PTL_CMD_UVD)  ? uvd : `PTL_BAD_CMD;

  // ---------------------------------------------------------------
  // link byte engine (word read / word write, low byte first)
  // ---------------------------------------------------------------
  ptl_state_t  state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  wlo;
  logic [15:0] txw;
  logic [1:0]  byte_idx;
  logic        rw;
  wire addr_hit = addr_ok && (shreg[7:1] == bus_addr);
  wire byte_end = (state == ST_RX) && scl_fall && (bitcnt == 4'h8);
  wire wr_fire  = byte_end && (byte_idx == 2'h3) && !rw;
  wire [15:0] wr_data = {shreg, wlo};
  // no clock stretching; starts ignored until the link is ready
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state    <= ST_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      wlo      <= 8'h00;
      txw      <= 16'h0000;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      cmd      <= 8'h00;
      sda_oe   <= 1'b0;
    end else if (stop_c) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c && bus_active) begin
      state    <= ST_RX;
      bitcnt   <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe   <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: sda_oe <= 1'b0;
        ST_RX: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            bitcnt   <= 4'h0;
            byte_idx <= byte_idx + 2'h1;
            if (byte_idx != 2'h0 || addr_hit) begin
              state  <= ST_ACK;
              sda_oe <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
            if (byte_idx == 2'h0) rw <= shreg[0];
            if (byte_idx == 2'h0) txw <= rd_value;
            if (byte_idx == 2'h1) cmd <= shreg;
            if (byte_idx == 2'h2) wlo <= shreg;
          end
        end
        ST_ACK: begin
          if (scl_fall && rw) begin
            state  <= ST_TX;
            sda_oe <= ~txw[7];
            shreg  <= {txw[6:0], 1'b0};
            bitcnt <= 4'h1;
          end else if (scl_fall) begin
            state  <= ST_RX;
            sda_oe <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall && bitcnt == 4'h8) begin
            state  <= ST_RACK;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe <= ~shreg[7];
            shreg  <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        end
        ST_RACK: begin
          // master ack moves on to the next byte of the word
          if (scl_rise) begin
            state <= sda_s ? ST_IDLE : ST_ACK;
            txw   <= {8'h00, txw[15:8]};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // variables and derived thresholds
  // ---------------------------------------------------------------
  wire wr_ok   = ~module_on & below_s & bias_s;
  wire ton_ok  = wr_data <= `PTL_TON_MAX;
  wire is_var  = (cmd == `PTL_CMD_OTF) | (cmd == `PTL_CMD_OTW) | (cmd == `PTL_CMD_OVF) |
                 (cmd == `PTL_CMD_OVW) | (cmd == `PTL_CMD_OCF) | (cmd == `PTL_CMD_OCW) |
                 (cmd == `PTL_CMD_UVD) | ((cmd == `PTL_CMD_TON) & ton_ok);
  wire lim_acc = wr_fire & wr_ok & is_var;
  wire oper_we = wr_fire & bias_s & (cmd == `PTL_CMD_OPER);
  wire [15:0] ovlo_drop = 16'((32'(ovf) * `PTL_OVLO_PCT) / `PTL_PCT_FULL);
  // refused writes simply fall through with no store
  always_ff @(posedge core_clk) begin
    if (srst) begin
      module_on <= 1'b0;
      ovf <= `PTL_RST_OVF;
      ovw <= `PTL_RST_OVF;
      ocf <= `PTL_RST_OCF;
      ocw <= `PTL_RST_OCF;
      otf <= `PTL_RST_OTF;
      otw <= `PTL_RST_OTF;
      ton <= `PTL_RST_TON;
      uvd <= `PTL_RST_UVD;
    end else begin
      if (oper_we) module_on <= wr_data[`PTL_OPER_ON_BIT];
      if (lim_acc && cmd == `PTL_CMD_OVF) ovf <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_OVW) ovw <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_OCF) ocf <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_OCW) ocw <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_OTF) otf <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_OTW) otw <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_TON) ton <= wr_data;
      if (lim_acc && cmd == `PTL_CMD_UVD) uvd <= wr_data;
    end
  end
  // thresholds follow one cycle behind their variables
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hi_side_overvoltage_lockout_point <= 16'h0000;
      hi_side_undervoltage_threshold    <= `PTL_UV_NOMINAL;
      start_delay_ms                    <= `PTL_UV_DELAY;
      sda_o                             <= 1'b0;
    end else begin
      hi_side_overvoltage_lockout_point <= ovf - ovlo_drop;
      hi_side_undervoltage_threshold <=
          uvd[`PTL_UVD_BIT] ? `PTL_UV_DEFAULT : `PTL_UV_NOMINAL;
      start_delay_ms <= `PTL_UV_DELAY + ton;
      sda_o          <= 1'b0;  // open drain: low whenever enabled
    end
  end

  // ---------------------------------------------------------------
  // nonvolatile commit
  // ---------------------------------------------------------------
  logic [23:0] commit_cnt;
  wire commit_done = commit_busy && !module_on && commit_cnt == 24'(COMMIT_CYC - 1);
  // count only while disabled; a new write restarts and wins over the finish
  always_ff @(posedge core_clk) begin
    if (srst) begin
      commit_busy <= 1'b0;
      commit_cnt  <= 24'h000000;
      nvm_commit  <= 1'b0;
    end else begin
      nvm_commit <= commit_done && !lim_acc;
      if (lim_acc || module_on) commit_cnt <= 24'h000000;
      else if (commit_busy) commit_cnt <= commit_cnt + 24'h000001;
      if (lim_acc) commit_busy <= 1'b1;
      else if (commit_done) commit_busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // read word load and scaled lockout figures, the latter checked against the scaled fault limit
  wire        rd_load     = byte_end && (byte_idx == 2'h0);
  wire [31:0] ovlo_scaled = 32'(hi_side_overvoltage_lockout_point) * `PTL_PCT_FULL
                            + 32'(ovf) * `PTL_OVLO_PCT;
  wire [31:0] ovf_scaled  = 32'(ovf) * `PTL_PCT_FULL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  lv_disabled_a: assert property (rd_load && cmd == `PTL_CMD_LV && !module_on
      |=> txw == `PTL_DIS_LV)
    else $error("disabled low-side voltage not default");
  tmp_disabled_a: assert property (rd_load && cmd == `PTL_CMD_TMP && !module_on
      |=> txw == `PTL_DIS_TMP)
    else $error("disabled temperature not default");
  rev_current_a: assert property (rd_load && !fwd_s
      && (cmd == `PTL_CMD_HI || cmd == `PTL_CMD_LI) |=> txw == 16'h0000)
    else $error("current reported in reverse");
  var_guard_a: assert property ($changed(ovf) |-> $past(wr_ok) && $past(wr_fire))
    else $error("limit changed without write conditions");
  wr_reject_a: assert property (wr_fire && !wr_ok |=> $stable(ton) && $stable(otf))
    else $error("refused write altered a variable");
  ovlo_point_a: assert property ($stable(ovf) && !$past(srst)
      |-> ovlo_scaled >= ovf_scaled && ovlo_scaled < ovf_scaled + `PTL_PCT_FULL)
    else $error("lockout point not three percent below fault limit");
  uv_thr_a: assert property ($stable(uvd) [*2] |-> hi_side_undervoltage_threshold
      == (uvd[0] ? `PTL_UV_DEFAULT : `PTL_UV_NOMINAL))
    else $error("undervoltage threshold wrong");
  ton_max_a: assert property (ton <= `PTL_TON_MAX ##1 $stable(ton)
      |-> start_delay_ms == `PTL_UV_DELAY + ton)
    else $error("turn-on delay out of range");
  oper_bias_a: assert property ($changed(module_on) |-> $past(bias_s))
    else $error("module switched without bias");
  early_drive_a: assert property (!bus_active |-> !sda_oe)
    else $error("link driven before ready");
  addr_fixed_a: assert property (addr_ok |=> $stable(bus_addr) && addr_ok)
    else $error("bus address moved");
  fast_hold_a: assert property (!tick_fast && !lose |=> $stable(snap_hv))
    else $error("telemetry refreshed off tick");
  cover_read_c: cover property (state == ST_RACK && scl_rise && sda_s);
  cover_write_c: cover property (lim_acc);
  cover_reject_c: cover property (wr_fire && !wr_ok);
  cover_commit_c: cover property (nvm_commit);
endmodule // ptl_core
`default_nettype wire

//--- tb/ptl_core_test.sv
// self-checking bench for the telemetry and limits command handler
`include "ptl_regs.svh"
`default_nettype none
module ptl_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         STRAP = 1000;
  localparam logic [6:0] ADDR  = `PTL_ADDR_BASE + 7'(STRAP * 4 / 825); // band 4
  logic        core_clk, srst, scl_i, sda_i, sda_oe, ack, dev_sda;
  logic        bias_supply_pin, hi_below_uv, fwd_dir, hi_present;
  logic        module_on, bus_active, commit_busy, nvm_commit;
  logic [11:0] strap_mv;
  logic [6:0]  bus_addr;
  logic [15:0] hi_v_raw, hi_i_raw, lo_v_raw, lo_i_raw, lo_r_raw, temp_raw, rd_val;
  logic [15:0] ovf, ovw, ocf, ocw, otf, otw, ton, uvd, start_delay_ms;
  logic [15:0] hi_side_overvoltage_lockout_point, hi_side_undervoltage_threshold;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [7:0]  lim_cmd [6] = '{`PTL_CMD_OVF, `PTL_CMD_OVW, `PTL_CMD_OCF,
                              `PTL_CMD_OCW, `PTL_CMD_OTF, `PTL_CMD_OTW};
  logic [15:0] lim_val [6] = '{16'h0FA0, 16'h0F00, 16'h1000, 16'h0800, 16'h0064, 16'h0050};

  ptl_core #(.FAST_CYC(20), .SLOW_CYC(50), .READY_CYC(30), .COMMIT_CYC(40)) DUT (
    .core_clk, .srst, .scl_i, .sda_i, .sda_o(dev_sda), .sda_oe, .bias_supply_pin, .hi_below_uv,
    .fwd_dir, .hi_present, .strap_mv, .hi_v_raw, .hi_i_raw, .lo_v_raw, .lo_i_raw,
    .lo_r_raw, .temp_raw, .module_on, .bus_active, .bus_addr, .ovf, .ovw, .ocf, .ocw,
    .otf, .otw, .ton, .uvd, .hi_side_overvoltage_lockout_point,
    .hi_side_undervoltage_threshold, .start_delay_ms, .commit_busy, .nvm_commit);

  ptl_host host (.core_clk, .sda_oe, .dev_sda, .scl_o(scl_i), .sda_o(sda_i));

  always #4 core_clk = ~core_clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    host.write_word(ADDR, cmd, data, ack);
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    host.read_word(ADDR, cmd, rd_val, ack);
    check(rd_val, exp);
  endtask

  // bounded wait for the commit pulse; module stays disabled meanwhile
  task automatic wait_commit();
    int n;
    n = 0;
    while (nvm_commit !== 1'b1 && n < 400) begin
      settle(1);
      n++;
    end
    check({15'h0, nvm_commit}, 16'h0001);
    settle(1);
    check({15'h0, commit_busy}, 16'h0000);
  endtask

  function automatic logic [15:0] lockout(input logic [15:0] v);
    return v - 16'((32'(v) * 3) / 100);
  endfunction

  function automatic logic [15:0] stored(input int i);
    logic [15:0] s [6];
    s = '{ovf, ovw, ocf, ocw, otf, otw};
    return s[i];
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    bias_supply_pin = 1'b0;
    hi_below_uv = 1'b1;
    fwd_dir = 1'b1;
    hi_present = 1'b1;
    strap_mv = 12'(STRAP);
    {hi_v_raw, hi_i_raw, lo_v_raw} = {16'h0F00, 16'h0DAC, 16'h00F0};
    {lo_i_raw, lo_r_raw, temp_raw} = {16'h1388, 16'h0064, 16'h0019};
    settle(8);
    srst = 1'b0;
    settle(2);
    check(ovf, 16'd4350);
    check(ovw, 16'd4350);
    check(ocf, 16'd5500);
    check(ocw, 16'd5500);
    check(otf, 16'd125);
    check(otw, 16'd125);
    check(ton, 16'd0);
    check(start_delay_ms, 16'd20);
    check(hi_side_overvoltage_lockout_point, lockout(16'd4350));
    check(hi_side_undervoltage_threshold, 16'd2250);
    // no bias yet: link must stay deaf
    wr(`PTL_CMD_TON, 16'h0005);
    check({15'h0, ack}, 16'h0000);
    bias_supply_pin = 1'b1;
    settle(20);
    check({15'h0, bus_active}, 16'h0000);
    settle(30);
    check({15'h0, bus_active}, 16'h0001);
    check({9'h0, bus_addr}, {9'h0, ADDR});
    strap_mv = 12'd3300;
    settle(5);
    check({9'h0, bus_addr}, {9'h0, ADDR});
    host.write_word(ADDR + 7'h1, `PTL_CMD_TON, 16'h0007, ack);
    check({15'h0, ack}, 16'h0000);
    check(ton, 16'd0);
    // telemetry while disabled
    rd(`PTL_CMD_HV, hi_v_raw);
    rd(`PTL_CMD_HI, hi_i_raw);
    rd(`PTL_CMD_LI, lo_i_raw);
    rd(`PTL_CMD_RES, lo_r_raw);
    rd(`PTL_CMD_LV, -16'd3000);
    rd(`PTL_CMD_TMP, -16'd273);
    fwd_dir = 1'b0;
    settle(30);
    rd(`PTL_CMD_HI, 16'h0000);
    rd(`PTL_CMD_LI, 16'h0000);
    fwd_dir = 1'b1;
    // limit writes with and without the write conditions met
    for (int i = 0; i < 6; i++) begin
      wr(lim_cmd[i], lim_val[i]);
      check(stored(i), lim_val[i]);
    end
    check(hi_side_overvoltage_lockout_point, lockout(16'h0FA0));
    check({15'h0, commit_busy}, 16'h0001);
    wait_commit();
    hi_below_uv = 1'b0;
    wr(`PTL_CMD_OVW, 16'h0123);
    check(ovw, 16'h0F00);
    hi_below_uv = 1'b1;
    bias_supply_pin = 1'b0;
    settle(5);
    wr(`PTL_CMD_OCW, 16'h0321);
    check(ocw, 16'h0800);
    wr(`PTL_CMD_OPER, 16'h0080);
    check({15'h0, module_on}, 16'h0000);
    bias_supply_pin = 1'b1;
    settle(5);
    wr(`PTL_CMD_TON, 16'd100);
    check(ton, 16'd100);
    check(start_delay_ms, 16'd120);
    wr(`PTL_CMD_TON, 16'd101);
    check(ton, 16'd100);
    wr(`PTL_CMD_UVD, 16'h0001);
    check(hi_side_undervoltage_threshold, 16'd2600);
    check(uvd, 16'h0001);
    wr(`PTL_CMD_UVD, 16'h0000);
    check(hi_side_undervoltage_threshold, 16'd2250);
    wait_commit();
    // enabled module: live readings, limit writes refused
    wr(`PTL_CMD_OPER, 16'h0080);
    check({15'h0, module_on}, 16'h0001);
    wr(`PTL_CMD_OVF, 16'h0111);
    check(ovf, 16'h0FA0);
    rd(`PTL_CMD_OVF, 16'h0FA0);
    rd(`PTL_CMD_OPER, 16'h0080);
    rd(`PTL_CMD_LV, lo_v_raw);
    rd(`PTL_CMD_TMP, temp_raw);
    wr(`PTL_CMD_OPER, 16'h0000);
    check({15'h0, module_on}, 16'h0000);
    // telemetry without bias, then loss of input power
    bias_supply_pin = 1'b0;
    hi_v_raw = 16'h0E00;
    settle(30);
    rd(`PTL_CMD_HV, 16'h0E00);
    hi_present = 1'b0;
    settle(30);
    rd(`PTL_CMD_HV, 16'h0000);
    complete_run();
  end
endmodule // ptl_core_test
`default_nettype wire

//--- tb/ptl_host.sv
// host controller model driving the two-wire management link
`default_nettype none
module ptl_host (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  input  wire logic dev_sda,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic host_sda;

  // ----------------------------------------
  // wired-and data line with pull-up
  // ----------------------------------------
  assign sda_o = host_sda & (~sda_oe | dev_sda);  // device value counts only while enabled

  initial begin
    scl_o = 1'b1;
    host_sda = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one link bit: data moves in the low phase, line read just before the fall
  task automatic put_bit(input logic b, output logic seen);
    wait_cyc(1);
    host_sda = b;
    wait_cyc(3);
    scl_o = 1'b1;
    wait_cyc(4);
    seen = sda_o;
    scl_o = 1'b0;
  endtask

  // start or repeated start; long low phase lets the device release first
  task automatic start_cond();
    wait_cyc(4);
    host_sda = 1'b1;
    wait_cyc(4);
    scl_o = 1'b1;
    wait_cyc(4);
    host_sda = 1'b0;
    wait_cyc(4);
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    wait_cyc(4);
    host_sda = 1'b0;
    wait_cyc(4);
    scl_o = 1'b1;
    wait_cyc(4);
    host_sda = 1'b1;
    wait_cyc(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // released line while reading; host acks all but the last byte
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(~more, s);
  endtask

  // word write, low byte first
  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                            input logic [15:0] data, output logic ack);
    logic a0, a1, a2, a3;
    start_cond();
    send_byte({adr, 1'b0}, a0);
    send_byte(cmd, a1);
    send_byte(data[7:0], a2);
    send_byte(data[15:8], a3);
    stop_cond();
    ack = a0 & a1 & a2 & a3;
  endtask

  // word read through a repeated start
  task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd,
                           output logic [15:0] data, output logic ack);
    logic a0, a1, a2;
    start_cond();
    send_byte({adr, 1'b0}, a0);
    send_byte(cmd, a1);
    start_cond();
    send_byte({adr, 1'b1}, a2);
    get_byte(1'b1, data[7:0]);
    get_byte(1'b0, data[15:8]);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask
endmodule // ptl_host
`default_nettype wire
